// ---- hdl/slave_master.sv ----
`timescale 1ns/10ps
module slave_master (
  // Serial link.
  slave_link_if.host                            LINK,
  // Clock and reset.
  input  wire logic                             REF_CLK,
  input  wire logic                             SRST,
  // Wishbone slave.
  input  wire logic                             WB_CYC_I,
  input  wire logic                             WB_STB_I,
  input  wire logic                             WB_WE_I,
  input  wire logic [slave_port_pkg::HW_AW-1:0] WB_ADR_I,
  input  wire logic [3:0]                       WB_SEL_I,
  input  wire logic [31:0]                      WB_DAT_I,
  output logic      [31:0]                      WB_DAT_O,
  output logic                                  WB_ACK_O
);
  import slave_port_pkg::*;

  host_state_e state_q;
  host_state_e state_d;
  logic        scl_s1_q;
  logic        scl_s2_q;
  logic        sda_s1_q;
  logic        sda_s2_q;
  logic [3:0]  ph_q;
  logic [3:0]  ph_d;
  logic [3:0]  step_q;
  logic [3:0]  step_d;
  logic        hi_q;
  logic        hi_d;
  logic [8:0]  tx_q;
  logic [8:0]  tx_d;
  logic [8:0]  sh_q;
  logic [8:0]  sh_d;
  logic [8:0]  rx_q;
  logic [8:0]  rx_d;
  logic        shift_q;
  logic        shift_d;
  logic        scl_low_q;
  logic        scl_low_d;
  logic        sda_low_q;
  logic        sda_low_d;
  logic        ack_q;
  logic        ack_d;
  logic [31:0] dat_q;
  logic [31:0] dat_d;
  logic        req;
  logic        go;
  logic        busy;
  logic        cnt_en;
  logic        done;

  assign req    = WB_CYC_I && WB_STB_I;
  assign go     = req && ack_q && WB_WE_I && WB_SEL_I[0];
  assign busy   = (state_q != H_IDLE);
  // A released clock counts only once the line is seen high, so stretching is honoured.
  assign cnt_en = scl_low_q || scl_s2_q;
  assign done   = cnt_en && ph_q == HALF_LAST;

  assign LINK.host_scl_o    = 1'b0;
  assign LINK.host_sda_o    = 1'b0;
  assign LINK.host_scl_oe_n = !scl_low_q;
  assign LINK.host_sda_oe_n = !sda_low_q;
  assign WB_DAT_O           = dat_q;
  assign WB_ACK_O           = ack_q;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    ack_d     = req && !ack_q;
    dat_d     = dat_q;
    tx_d      = tx_q;
    shift_d   = shift_q;
    state_d   = state_q;
    ph_d      = ph_q;
    step_d    = step_q;
    hi_d      = hi_q;
    sh_d      = sh_q;
    rx_d      = rx_q;
    scl_low_d = scl_low_q;
    sda_low_d = sda_low_q;
    if (req && !ack_q) begin
      case (WB_ADR_I)
        HW_CMD:  dat_d = {28'h0000000, shift_q, 3'h0};
        HW_TX:   dat_d = {23'h000000, tx_q};
        HW_RX:   dat_d = {15'h0000, busy, 7'h00, rx_q};
        default: dat_d = 32'h00000000;
      endcase
    end
    if (go && WB_ADR_I == HW_TX) begin
      tx_d = WB_DAT_I[8:0];
    end
    if (busy) begin
      ph_d = done ? 4'h0 : (cnt_en ? ph_q + 4'h1 : ph_q);
    end
    case (state_q)
      H_IDLE: begin
        // Commands that arrive while busy are dropped.
        if (go && WB_ADR_I == HW_CMD) begin
          shift_d = WB_DAT_I[CMD_SHIFT];
          ph_d    = 4'h0;
          step_d  = 4'h0;
          hi_d    = 1'b0;
          sh_d    = tx_q;
          if (WB_DAT_I[CMD_START]) begin
            state_d = H_START;
          end else if (WB_DAT_I[CMD_STOP]) begin
            state_d = H_STOP;
          end else if (WB_DAT_I[CMD_BYTE]) begin
            state_d = H_BYTE;
          end
        end
      end
      H_START: begin
        case (step_q)
          4'h0:    sda_low_d = 1'b0;
          4'h1:    scl_low_d = 1'b0;
          4'h2:    sda_low_d = 1'b1;
          default: scl_low_d = 1'b1;
        endcase
        if (done) begin
          step_d = step_q + 4'h1;
          if (step_q == START_LAST) begin
            state_d = H_IDLE;
          end
        end
      end
      H_STOP: begin
        case (step_q)
          4'h0:    sda_low_d = 1'b1;
          4'h1:    scl_low_d = 1'b0;
          default: sda_low_d = 1'b0;
        endcase
        if (done) begin
          step_d = step_q + 4'h1;
          if (step_q == STOP_LAST) begin
            state_d = H_IDLE;
          end
        end
      end
      H_BYTE: begin
        if (!hi_q) begin
          scl_low_d = 1'b1;
          // Data changes mid-low so it never moves while the clock is high.
          if (ph_q == SDA_SET) begin
            sda_low_d = !sh_q[8];
          end
          if (done) begin
            hi_d = 1'b1;
          end
        end else begin
          scl_low_d = 1'b0;
          if (done) begin
            rx_d = {rx_q[7:0], sda_s2_q};
            sh_d = {sh_q[7:0], 1'b1};
            hi_d = 1'b0;
            if (step_q == (shift_q ? LAST_CNT : BYTE_CNT)) begin
              state_d   = H_IDLE;
              scl_low_d = !shift_q;
            end else begin
              step_d = step_q + 4'h1;
            end
          end
        end
      end
      default: state_d = H_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      state_q   <= H_IDLE;
      scl_s1_q  <= 1'b1;
      scl_s2_q  <= 1'b1;
      sda_s1_q  <= 1'b1;
      sda_s2_q  <= 1'b1;
      ph_q      <= 4'h0;
      step_q    <= 4'h0;
      hi_q      <= 1'b0;
      tx_q      <= 9'h1ff;
      sh_q      <= 9'h1ff;
      rx_q      <= 9'h000;
      shift_q   <= 1'b0;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      ack_q     <= 1'b0;
      dat_q     <= 32'h00000000;
    end else begin
      state_q   <= state_d;
      scl_s1_q  <= LINK.scl;
      scl_s2_q  <= scl_s1_q;
      sda_s1_q  <= LINK.sda;
      sda_s2_q  <= sda_s1_q;
      ph_q      <= ph_d;
      step_q    <= step_d;
      hi_q      <= hi_d;
      tx_q      <= tx_d;
      sh_q      <= sh_d;
      rx_q      <= rx_d;
      shift_q   <= shift_d;
      scl_low_q <= scl_low_d;
      sda_low_q <= sda_low_d;
      ack_q     <= ack_d;
      dat_q     <= dat_d;
    end
  end
endmodule

// ---- hdl/slave_port.sv ----
// Design decision made here: a plain CPU register port.
`timescale 1ns/10ps
module slave_port (
  // Serial link.
  slave_link_if.dev                          LINK,
  // Clock and reset.
  input  wire logic                          REF_CLK,
  input  wire logic                          SRST,
  // CPU register port.
  input  wire logic                          REG_SEL,
  input  wire logic                          REG_WE,
  input  wire logic [slave_port_pkg::AW-1:0] REG_ADDR,
  input  wire logic [slave_port_pkg::DW-1:0] REG_WDATA,
  output logic      [slave_port_pkg::DW-1:0] REG_RDATA,
  // Interrupt request.
  output logic                               IRQ
);
  import slave_port_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic       scl_s1_q, scl_s1_d;
  logic       scl_s2_q, scl_s2_d;
  logic       scl_p_q, scl_p_d;
  logic       scl_f_q, scl_f_d;
  logic       sda_s1_q, sda_s1_d;
  logic       sda_s2_q, sda_s2_d;
  logic       sda_p_q, sda_p_d;
  logic       sda_f_q, sda_f_d;
  logic [7:0] ctl_q, ctl_d;
  logic [7:0] pctl_q, pctl_d;
  logic [7:0] buf_q, buf_d;
  logic [7:0] adr_q, adr_d;
  logic [7:0] rx_q, rx_d;
  logic [7:0] tx_q, tx_d;
  logic [3:0] cnt_q, cnt_d;
  logic       tak_q, tak_d;
  logic       rak_q, rak_d;
  logic       aas_q, aas_d;
  logic       ad0_q, ad0_d;
  logic       ack_slot_q, ack_slot_d;
  logic       first_q, first_d;
  logic       scl_low_q, scl_low_d;
  logic       sda_low_q, sda_low_d;
  logic [7:0] rdata_q, rdata_d;
  logic       irq_q, irq_d;
  logic       scl_n, sda_n;
  logic       shift_m, run, direction_bit, always_selected, byte_done_flag, sel;
  logic       rise, fall, start, stop;

  // Address hit for the first byte; zero byte is the general call.
  function automatic logic addr_hit(input logic [7:0] rx, input logic [7:0] adr,
                                    input logic gc_only);
    logic gc;
    gc = (rx == 8'h00);
    addr_hit = !adr[ADR_CMPD] && (gc || (!gc_only && rx[7:1] == adr[6:0]));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  assign shift_m = pctl_q[PC_SHIFT];
  assign run     = ctl_q[CTL_RUN];
  assign direction_bit     = ctl_q[CTL_TRX];
  assign always_selected     = ctl_q[CTL_ALS];
  assign byte_done_flag     = ctl_q[CTL_FLG];
  assign sel     = aas_q || always_selected;

  // A one-sample glitch filter in bus mode, none in shift mode.
  assign scl_n = (shift_m || scl_s2_q == scl_p_q) ? scl_s2_q : scl_f_q;
  assign sda_n = (shift_m || sda_s2_q == sda_p_q) ? sda_s2_q : sda_f_q;
  // The master supplies every clock edge; no edge is made here.
  assign rise  = run && scl_n && !scl_f_q;
  assign fall  = run && !scl_n && scl_f_q;
  assign start = run && !shift_m && scl_n && scl_f_q && sda_f_q && !sda_n;
  assign stop  = run && !shift_m && scl_n && scl_f_q && !sda_f_q && sda_n;

  assign LINK.dev_scl_o    = 1'b0;
  assign LINK.dev_sda_o    = 1'b0;
  assign LINK.dev_scl_oe_n = !scl_low_q;
  assign LINK.dev_sda_oe_n = !sda_low_q;
  assign REG_RDATA         = rdata_q;
  assign IRQ               = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    scl_s1_d   = LINK.scl;
    scl_s2_d   = scl_s1_q;
    scl_p_d    = scl_s2_q;
    scl_f_d    = scl_n;
    sda_s1_d   = LINK.sda;
    sda_s2_d   = sda_s1_q;
    sda_p_d    = sda_s2_q;
    sda_f_d    = sda_n;
    ctl_d      = ctl_q;
    pctl_d     = pctl_q;
    buf_d      = buf_q;
    adr_d      = adr_q;
    rx_d       = rx_q;
    tx_d       = tx_q;
    cnt_d      = cnt_q;
    tak_d      = tak_q;
    rak_d      = rak_q;
    aas_d      = aas_q;
    ad0_d      = ad0_q;
    ack_slot_d = ack_slot_q;
    first_d    = first_q;
    // Software writes first, so a hardware set in the same cycle wins.
    if (REG_SEL && REG_WE) begin
      case (REG_ADDR)
        CTL_ADDR:  ctl_d = REG_WDATA;
        STA_ADDR:  tak_d = REG_WDATA[STA_TAK];
        PCTL_ADDR: pctl_d = REG_WDATA;
        BUF_ADDR: begin
          if (!shift_m && !run) begin
            adr_d = REG_WDATA;
          end else begin
            buf_d = REG_WDATA;
            if (byte_done_flag || (shift_m && !run)) begin
              tx_d = REG_WDATA;
            end
          end
        end
        default: ;
      endcase
    end
    if (!run) begin
      cnt_d      = 4'h0;
      ack_slot_d = 1'b0;
      first_d    = 1'b0;
      rak_d      = 1'b0;
      aas_d      = 1'b0;
      ad0_d      = 1'b0;
    end else if (start || stop) begin
      cnt_d          = 4'h0;
      ack_slot_d     = 1'b0;
      first_d        = start;
      aas_d          = 1'b0;
      ad0_d          = 1'b0;
      ctl_d[CTL_TRX] = 1'b0;
      tak_d          = 1'b1;
      if (stop) begin
        ctl_d[CTL_SPF] = 1'b1;
      end
      if (start) begin
        tx_d = buf_q;
      end
    end else if (rise) begin
      if (cnt_q < BYTE_CNT) begin
        rx_d = {rx_q[6:0], sda_f_q};
      end
      if (shift_m) begin
        if (cnt_q == LAST_CNT) begin
          cnt_d          = 4'h0;
          ctl_d[CTL_FLG] = 1'b1;
          buf_d          = {rx_q[6:0], sda_f_q};
        end else begin
          cnt_d = cnt_q + 4'h1;
        end
      end else begin
        if (cnt_q == BYTE_CNT) begin
          rak_d = sda_f_q;
          if (sda_f_q) begin
            ctl_d[CTL_TRX] = 1'b0;
            tak_d          = 1'b1;
          end
        end
        if (cnt_q != ACK_CNT) begin
          cnt_d = cnt_q + 4'h1;
        end
      end
    end else if (fall) begin
      if (shift_m && byte_done_flag) begin
        ctl_d[CTL_SPF] = 1'b1;
      end
      // Data moves out MSB first, one bit per falling edge.
      if (cnt_q != 4'h0 && cnt_q < BYTE_CNT) begin
        tx_d = {tx_q[6:0], 1'b1};
      end
      if (!shift_m && cnt_q == BYTE_CNT) begin
        ack_slot_d = 1'b1;
        if (first_q) begin
          aas_d = addr_hit(rx_q, adr_q, 1'b0);
          ad0_d = addr_hit(rx_q, adr_q, 1'b1);
        end
        if (first_q || sel) begin
          buf_d = rx_q;
        end
        if ((aas_d || always_selected) && (ctl_q[CTL_EIGHTH_CLOCK_EVENT] || ad0_d)) begin
          ctl_d[CTL_FLG] = 1'b1;
        end
      end
      if (!shift_m && cnt_q == ACK_CNT) begin
        cnt_d      = 4'h0;
        ack_slot_d = 1'b0;
        first_d    = 1'b0;
        if (sel) begin
          ctl_d[CTL_FLG] = 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    // Software releases the clock by clearing the flag or the run bit, or by selecting shift mode.
    scl_low_d = run && !shift_m && byte_done_flag && !scl_f_q;
    sda_low_d = 1'b0;
    if (run && shift_m) begin
      sda_low_d = direction_bit && !tx_q[7];
    end else if (run && ack_slot_q) begin
      if (direction_bit) begin
        sda_low_d = 1'b0;
      end else if (first_q) begin
        sda_low_d = (aas_q && !ad0_q) || !tak_q;
      end else begin
        sda_low_d = sel && !tak_q;
      end
    end else if (run && direction_bit && !first_q) begin
      sda_low_d = sel && !tx_q[7];
    end
    case (REG_ADDR)
      CTL_ADDR:  rdata_d = ctl_q;
      STA_ADDR:  rdata_d = shift_m ? {1'b0, tak_q, 6'h00}
                                   : {rak_q, tak_q, aas_q, ad0_q, 4'h0};
      PCTL_ADDR: rdata_d = pctl_q;
      BUF_ADDR:  rdata_d = (!shift_m && !run) ? adr_q : buf_q;
      default:   rdata_d = 8'h00;
    endcase
    irq_d = (ctl_q[CTL_SPF] && ctl_q[CTL_STOP_IRQ_ENABLE]) || (byte_done_flag && ctl_q[CTL_IE]);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      {scl_s1_q, scl_s2_q, scl_p_q, scl_f_q, sda_s1_q, sda_s2_q, sda_p_q, sda_f_q} <= 8'hff;
      ctl_q      <= REG_RST;
      pctl_q     <= REG_RST;
      buf_q      <= REG_RST;
      adr_q      <= REG_RST;
      rx_q       <= 8'h00;
      tx_q       <= 8'hff;
      cnt_q      <= 4'h0;
      tak_q      <= 1'b0;
      rak_q      <= 1'b0;
      aas_q      <= 1'b0;
      ad0_q      <= 1'b0;
      ack_slot_q <= 1'b0;
      first_q    <= 1'b0;
      scl_low_q  <= 1'b0;
      sda_low_q  <= 1'b0;
      rdata_q    <= 8'h00;
      irq_q      <= 1'b0;
    end else begin
      {scl_s1_q, scl_s2_q, scl_p_q, scl_f_q} <= {scl_s1_d, scl_s2_d, scl_p_d, scl_f_d};
      {sda_s1_q, sda_s2_q, sda_p_q, sda_f_q} <= {sda_s1_d, sda_s2_d, sda_p_d, sda_f_d};
      ctl_q      <= ctl_d;
      pctl_q     <= pctl_d;
      buf_q      <= buf_d;
      adr_q      <= adr_d;
      rx_q       <= rx_d;
      tx_q       <= tx_d;
      cnt_q      <= cnt_d;
      tak_q      <= tak_d;
      rak_q      <= rak_d;
      aas_q      <= aas_d;
      ad0_q      <= ad0_d;
      ack_slot_q <= ack_slot_d;
      first_q    <= first_d;
      scl_low_q  <= scl_low_d;
      sda_low_q  <= sda_low_d;
      rdata_q    <= rdata_d;
      irq_q      <= irq_d;
    end
  end
endmodule

// ---- shared/slave_link_if.sv ----
`timescale 1ns/10ps
interface slave_link_if;
  logic dev_scl_o;
  logic dev_scl_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic scl;
  logic sda;
  // Open-drain wires: released lines are pulled high.
  assign scl = (dev_scl_oe_n | dev_scl_o) & (host_scl_oe_n | host_scl_o);
  assign sda = (dev_sda_oe_n | dev_sda_o) & (host_sda_oe_n | host_sda_o);
  modport dev (input scl, input sda, output dev_scl_o, output dev_scl_oe_n,
               output dev_sda_o, output dev_sda_oe_n);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe_n,
                output host_sda_o, output host_sda_oe_n);
endinterface

// ---- shared/slave_port_pkg.sv ----
package slave_port_pkg;
  localparam int         AW        = 16;
  localparam int         DW        = 8;
  localparam logic [15:0] CTL_ADDR  = 16'h7fe8;
  localparam logic [15:0] STA_ADDR  = 16'h7fe9;
  localparam logic [15:0] PCTL_ADDR = 16'h7fea;
  localparam logic [15:0] BUF_ADDR  = 16'h7feb;
  localparam logic [7:0]  REG_RST   = 8'h00;
  localparam int         CTL_RUN   = 7;
  localparam int         CTL_TRX   = 6;
  localparam int         CTL_ALS   = 5;
  localparam int         CTL_EIGHTH_CLOCK_EVENT  = 4;
  localparam int         CTL_SPF   = 3;
  localparam int         CTL_STOP_IRQ_ENABLE  = 2;
  localparam int         CTL_FLG   = 1;
  localparam int         CTL_IE    = 0;
  localparam int         STA_TAK   = 6;
  localparam int         PC_SHIFT  = 6;
  localparam int         ADR_CMPD  = 7;
  localparam logic [3:0] LAST_CNT  = 4'h7;
  localparam logic [3:0] BYTE_CNT  = 4'h8;
  localparam logic [3:0] ACK_CNT   = 4'h9;
  // Link timing for the master end.
  localparam int         CLK_NS    = 40;
  localparam int         HALF_NS   = 400;
  localparam logic [3:0] HALF_LAST = 4'((HALF_NS + CLK_NS - 1) / CLK_NS - 1);
  localparam logic [3:0] SDA_SET   = 4'h3;
  localparam logic [3:0] START_LAST = 4'h3;
  localparam logic [3:0] STOP_LAST = 4'h2;
  // Master end Wishbone map.
  localparam int         HW_AW     = 4;
  localparam logic [3:0] HW_CMD    = 4'h0;
  localparam logic [3:0] HW_TX     = 4'h4;
  localparam logic [3:0] HW_RX     = 4'h8;
  localparam int         CMD_START = 0;
  localparam int         CMD_STOP  = 1;
  localparam int         CMD_BYTE  = 2;
  localparam int         CMD_SHIFT = 3;
  typedef enum logic [3:0] {
    H_IDLE  = 4'b0001,
    H_START = 4'b0010,
    H_BYTE  = 4'b0100,
    H_STOP  = 4'b1000
  } host_state_e;
endpackage

// ---- tb/slave_port_asserts.sv ----
`timescale 1ns/10ps
module slave_port_asserts #(
  parameter logic [6:0] ADR = 7'h2a
) (
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic SRST,
  // Link wires and enables.
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_scl_oe_n,
  input wire logic dev_sda_oe_n,
  input wire logic host_scl_oe_n
);
  logic       scl_q, sda_q, act_q, act_d, first_q, first_d, start, stop, rise;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] byte_q, byte_d;
  logic [4:0] low_q, low_d;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  // Only the master makes a start; in shift mode the device may move data with the clock high.
  // A stop only counts after a start, so shift-mode traffic never looks like bus traffic.
  assign start = scl && scl_q && sda_q && !sda && dev_sda_oe_n;
  assign stop  = scl && scl_q && !sda_q && sda && act_q;
  assign rise  = scl && !scl_q;
  always_comb begin
    act_d   = (act_q || start) && !stop;
    first_d = first_q;
    cnt_d   = cnt_q;
    byte_d  = byte_q;
    low_d   = host_scl_oe_n ? 5'h00 : low_q + {4'h0, low_q != 5'h1f};
    if (start || stop) begin
      first_d = start;
      cnt_d   = 4'h0;
      byte_d  = 8'h00;
    end else if (rise) begin
      first_d = first_q && cnt_q != 4'h9;
      cnt_d   = (cnt_q == 4'h9) ? 4'h1 : cnt_q + 4'h1;
      byte_d  = (cnt_q < 4'h8) ? {byte_q[6:0], sda} : byte_q;
    end
  end
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      {scl_q, sda_q, act_q, first_q} <= 4'hc;
      {cnt_q, byte_q, low_q}         <= '0;
    end else begin
      {scl_q, sda_q, act_q, first_q} <= {scl, sda, act_d, first_d};
      {cnt_q, byte_q, low_q}         <= {cnt_d, byte_d, low_d};
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence ack_rise_first;
    first_q && cnt_q == 4'h8 && rise;
  endsequence
  sequence ack_fall_match;
    first_q && cnt_q == 4'h9 && $fell(scl) && byte_q[7:1] == ADR && byte_q != 8'h00;
  endsequence
  a_reset_lines_free: assert property ($fell(SRST) |-> dev_scl_oe_n && dev_sda_oe_n)
    else $error("Link driven right after reset.");
  a_stretch_on_low: assert property ($fell(dev_scl_oe_n) |-> !$past(scl))
    else $error("Clock pulled low while it was high.");
  a_data_scl_low: assert property (act_q && $changed(dev_sda_oe_n) |-> !scl)
    else $error("Data line changed while clock high.");
  a_first_ack_value: assert property (ack_rise_first |->
    dev_sda_oe_n == !(byte_q[7:1] == ADR && byte_q != 8'h00))
    else $error("Wrong acknowledge on first byte.");
  a_match_stretch: assert property (ack_fall_match |-> ##[1:12] !dev_scl_oe_n)
    else $error("No clock hold after matched address.");
  a_stop_release: assert property (stop |=> dev_sda_oe_n [*8])
    else $error("Data line driven after stop.");
  a_start_release: assert property (start |=> dev_sda_oe_n [*4])
    else $error("Data line driven after start.");
  a_host_low_half: assert property ($rose(host_scl_oe_n) |-> low_q >= 5'h08)
    else $error("Clock low half too short.");
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  import slave_port_pkg::*;
  localparam logic [6:0] SADR = 7'h2a;
  logic        clk = 1'b0, srst = 1'b1, sel = 1'b0, we = 1'b0, irq, ack;
  logic        cyc = 1'b0, stb = 1'b0, wwe = 1'b0;
  logic [3:0]  wadr = '0, wsel = '0;
  logic [7:0]  wdata = '0, rdata, r, t;
  logic [15:0] addr = '0;
  logic [31:0] wdat = '0, wq, rd, got_val, exp_q[$];
  int          miscompares = 0, checks_done = 0;
  event        got;
  // Address byte cases: address register, control, byte sent, status, control seen.
  logic [7:0]  tab [4][5] = '{'{8'h2a, 8'h80, 8'h56, 8'hc0, 8'h80},
                             '{8'h2a, 8'h81, 8'h00, 8'hf0, 8'h83},
                             '{8'haa, 8'h80, 8'h00, 8'hc0, 8'h80},
                             '{8'h2a, 8'ha0, 8'h56, 8'hc0, 8'ha2}};
  always #20 clk = ~clk;
  slave_link_if link ();
  slave_port u_slave_port (.LINK(link.dev), .REF_CLK(clk), .SRST(srst), .REG_SEL(sel),
    .REG_WE(we), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .IRQ(irq));
  slave_master u_slave_master (.LINK(link.host), .REF_CLK(clk), .SRST(srst),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(wwe), .WB_ADR_I(wadr), .WB_SEL_I(wsel),
    .WB_DAT_I(wdat), .WB_DAT_O(wq), .WB_ACK_O(ack));
  slave_port_asserts #(.ADR(SADR)) u_asserts (.REF_CLK(clk), .SRST(srst), .scl(link.scl),
    .sda(link.sda), .dev_scl_oe_n(link.dev_scl_oe_n), .dev_sda_oe_n(link.dev_sda_oe_n),
    .host_scl_oe_n(link.host_scl_oe_n));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic note(input logic [31:0] seen, input logic [31:0] exp);
    exp_q.push_back(exp);
    got_val = seen;
    -> got;
    #1;
  endtask
  initial forever begin
    @(got);
    check(got_val, exp_q.pop_front());
  end
  task automatic finish_test();
    if (miscompares == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic dev_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    {sel, we, addr, wdata} <= {2'b11, a, d};
    @(posedge clk);
    {sel, we} <= 2'b00;
  endtask
  task automatic dev_rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    {sel, we, addr} <= {2'b10, a};
    @(posedge clk);
    sel <= 1'b0;
    #1;
    note({24'h0, rdata}, {24'h0, e});
  endtask
  task automatic irq_is(input logic e);
    repeat (3) @(posedge clk);
    #1;
    note({31'h0, irq}, {31'h0, e});
  endtask
  // Only the bench timeout ends a wait, so a dead master shows up as a mismatch.
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, wwe, wadr, wsel, wdat} <= {2'b11, w, a, 4'hf, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = wq;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic mop(input logic [3:0] cmd, input logic [8:0] tx);
    wb(1'b1, HW_TX, {23'h0, tx});
    wb(1'b1, HW_CMD, {28'h0, cmd});
    do begin
      wb(1'b0, HW_RX, 32'h0);
    end while (rd[16] !== 1'b0);
    repeat (8) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(75));
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 5; i++) dev_rd(CTL_ADDR + 16'(i), REG_RST);
    dev_wr(BUF_ADDR, {1'b0, SADR});
    dev_rd(BUF_ADDR, {1'b0, SADR});
    dev_wr(CTL_ADDR, 8'h81);
    mop(4'h1, 9'h1ff);
    mop(4'h4, {SADR, 2'b01});
    note({31'h0, rd[0]}, 32'h0);
    irq_is(1'b1);
    dev_rd(STA_ADDR, 8'h60);
    dev_rd(CTL_ADDR, 8'h83);
    dev_rd(BUF_ADDR, {SADR, 1'b0});
    dev_wr(STA_ADDR, 8'h00);
    dev_wr(CTL_ADDR, 8'h81);
    r = 8'($urandom());
    mop(4'h4, {r, 1'b1});
    note({23'h0, rd[8:0]}, {23'h0, r, 1'b0});
    dev_rd(BUF_ADDR, r);
    dev_wr(CTL_ADDR, 8'hc3);
    t = 8'($urandom());
    dev_wr(BUF_ADDR, t);
    dev_wr(CTL_ADDR, 8'hc1);
    mop(4'h4, 9'h1ff);
    note({23'h0, rd[8:0]}, {23'h0, t, 1'b1});
    dev_rd(CTL_ADDR, 8'h83);
    dev_rd(STA_ADDR, 8'he0);
    dev_wr(CTL_ADDR, 8'h81);
    mop(4'h2, 9'h1ff);
    dev_rd(CTL_ADDR, 8'h89);
    dev_rd(STA_ADDR, 8'hc0);
    dev_wr(CTL_ADDR, 8'h8c);
    irq_is(1'b1);
    dev_wr(CTL_ADDR, 8'h84);
    irq_is(1'b0);
    for (int i = 0; i < 4; i++) begin
      dev_wr(CTL_ADDR, 8'h00);
      dev_wr(BUF_ADDR, tab[i][0]);
      dev_wr(CTL_ADDR, tab[i][1]);
      mop(4'h1, 9'h1ff);
      // A general call also holds the clock at the eighth edge, so release it mid-byte.
      fork
        mop(4'h4, {tab[i][2], 1'b1});
        if (i == 1) begin
          wait (irq === 1'b1);
          dev_wr(CTL_ADDR, 8'h81);
        end
      join
      note({31'h0, rd[0]}, 32'h1);
      dev_rd(STA_ADDR, tab[i][3]);
      dev_rd(CTL_ADDR, tab[i][4]);
      dev_wr(CTL_ADDR, tab[i][1]);
      mop(4'h2, 9'h1ff);
    end
    dev_wr(CTL_ADDR, 8'h00);
    dev_wr(PCTL_ADDR, 8'h40);
    dev_wr(CTL_ADDR, 8'h40);
    t = 8'($urandom());
    dev_wr(BUF_ADDR, t);
    dev_wr(CTL_ADDR, 8'hc0);
    mop(4'hc, 9'h1ff);
    note({24'h0, rd[7:0]}, {24'h0, t});
    dev_rd(CTL_ADDR, 8'hc2);
    dev_rd(BUF_ADDR, t);
    mop(4'hc, 9'h1ff);
    dev_rd(CTL_ADDR, 8'hca);
    dev_wr(CTL_ADDR, 8'h80);
    r = 8'($urandom());
    mop(4'hc, {r, 1'b1});
    dev_rd(BUF_ADDR, r);
    dev_wr(CTL_ADDR, 8'h00);
    mop(4'hc, {~r, 1'b1});
    dev_rd(CTL_ADDR, 8'h00);
    finish_test();
  end
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    finish_test();
  end
endmodule
